/* src/amp_remote_io.sv */
// Purpose: remote monitor and control logic of the power amplifier
// Assumes: serial byte framing and message parsing sit outside and deliver
//   decoded commands; the register port is the local setup path
// Notes: answers appear one cycle after the command
// Notes on behaviour
// - one line standard enabled at once
// - frame is start, eight data, one stop
// - eight baud rates, address 0 to 255
// - serial cannot change line, baud, address
// - obey own address or broadcast zero
// - latched relay released by reset when clear
// - attention relay cleared by reset or request
// - active relay follows present fault only, attention request when panel attached
// - panel relay always attention; no active mode
// - short summary query answered with summary
// - detailed query answered with fault codes
// - eight inputs, eight relays, analog power
// - one byte code selects input function
// - user fault inputs active low or high
// - inhibit inputs active low or high
// - fault inputs work in every mode
// - input functions read and written serially
// - input state high, low or error
// - unassigned inputs latch high until a serial state read
// - output functions serial; none or power fault
// - power fault outside upper or lower limit
// - unassigned relays rest open after power-up
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "amp_rio_cfg.svh"

module amp_remote_io (
  input wire logic clk_i,                 // system clock, 200 MHz
  input wire logic srst_i,                // synchronous reset, high
  input wire logic [7:0] reg_addr_i,      // register byte address
  input wire logic [31:0] reg_wdata_i,    // register write data
  input wire logic reg_we_i,              // register write strobe
  input wire logic reg_re_i,              // register read strobe
  output logic [31:0] reg_rdata_o,        // read data, cycle after strobe
  input wire amp_rio_pkg::cmd_s cmd_i,    // decoded serial command
  output amp_rio_pkg::resp_s resp_o,      // serial answer
  input wire logic [7:0] fault_i,         // amplifier fault conditions
  input wire logic [7:0] warn_i,          // amplifier warning conditions
  input wire logic [7:0] power_i,         // measured output power
  input wire logic [7:0] pio_pin_i,       // parallel input pins
  input wire logic pio_err_i,             // parallel board faulty
  output logic [3:0] line_en_o,           // one-hot line standard enable
  output logic [19:0] baud_div_o,         // clocks per bit
  output logic [3:0] frame_bits_o,        // data bits per character
  output logic relay_o,                   // serial port relay, 1 = fault
  output logic panel_relay_o,             // panel relay, 1 = fault
  output logic [7:0] pio_relay_o,         // parallel relays, 1 = energised
  output logic tx_inhibit_o,              // inhibit rf output
  output logic mute_o,                    // mute amplifier
  output logic [7:0] analog_o             // analog power level
);
  import amp_rio_pkg::*;

  // ----
  // state
  // ----
  typedef struct packed {
    line_std_e line;          // line standard
    logic [2:0] baud_sel;     // baud selection
    logic [7:0] unit_addr;    // own address
    relay_mode_e mode;        // relay mode
    logic panel;              // remote panel attached
    logic [7:0] upper_power_limit; // upper power limit
    logic [7:0] lower_power_limit; // lower power limit
    logic [7:0][7:0] in_fn;   // input function codes
    logic [7:0][7:0] out_fn;  // output function codes
    logic [7:0] out_ctrl;     // unassigned relay control
    logic [7:0] latched;      // latched highs of unassigned inputs
    logic flt_latch;          // latched fault
    logic svc_req;            // attention request
    logic mute;               // mute control
    logic relay;              // serial relay
    logic panel_relay;        // panel relay
    logic [7:0] pio_relay;    // parallel relays
    logic tx_inhibit;         // inhibit
    logic [3:0] line_en;      // line enables
    logic [19:0] baud_div;    // baud divisor
    logic [7:0] analog;       // analog level
    resp_s resp;              // serial answer
    logic [31:0] rdata;       // register read data
  } core_s;

  core_s st_r;   // registered state
  core_s st_nxt; // next state

  logic [7:0] lvl;   // settled input levels
  logic [7:0] rise;  // rising edges
  logic [7:0] fall;  // falling edges

  // ----
  // helpers
  // ----
  // clocks per bit for each baud selection
  function automatic logic [19:0] baud_div(input logic [2:0] sel);
    logic [31:0] rate;
    rate = 32'd9600;
    unique case (sel)
      3'h0: rate = 32'd300;
      3'h1: rate = 32'd1200;
      3'h2: rate = 32'd2400;
      3'h3: rate = 32'd4800;
      3'h4: rate = 32'd9600;
      3'h5: rate = 32'd14400;
      3'h6: rate = 32'd19200;
      3'h7: rate = 32'd28800;
    endcase
    baud_div = 20'(`CLK_HZ / rate);
  endfunction

  // one-hot enable of the chosen line standard
  function automatic logic [3:0] line_onehot(input line_std_e l);
    line_onehot = 4'h1 << l;
  endfunction

  // pack four function codes into one word
  function automatic logic [31:0] pack4(input logic [7:0][7:0] f, input logic hi);
    pack4 = hi ? {f[7], f[6], f[5], f[4]} : {f[3], f[2], f[1], f[0]};
  endfunction

  // ----
  // input synchroniser
  // ----
  pio_input_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(pio_pin_i),
    .level_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  // ----
  // next state
  // ----
  always_comb begin
    logic hit;          // command addressed to us
    logic [7:0] uflt;   // user fault per input
    logic [7:0] inh;    // inhibit per input
    logic pwr_flt;      // output power fault
    logic any_fault;    // any fault present
    logic any_warn;     // any warning present
    logic rst_ev;       // fault reset event
    logic clr_ev;       // clear request event
    logic ok_rst;       // successful fault reset
    hit = 1'b0;
    uflt = 8'h00;
    inh = 8'h00;
    pwr_flt = 1'b0;
    any_fault = 1'b0;
    any_warn = 1'b0;
    rst_ev = 1'b0;
    clr_ev = 1'b0;
    ok_rst = 1'b0;
    st_nxt = st_r;
    st_nxt.resp = '0;
    st_nxt.rdata = '0;

    // address filter with broadcast
    hit = cmd_i.valid &&
          (cmd_i.addr == st_r.unit_addr || cmd_i.addr == `BCAST_ADDR);

    // level functions of the inputs
    for (int i = 0; i < 8; i++) begin
      // fault inputs are never gated by local or maintenance mode
      uflt[i] = (st_r.in_fn[i] == `IFN_UFLT_LOW && !lvl[i]) ||
                (st_r.in_fn[i] == `IFN_UFLT_HIGH && lvl[i]);
      inh[i] = (st_r.in_fn[i] == `IFN_INH_LOW && !lvl[i]) ||
               (st_r.in_fn[i] == `IFN_INH_HIGH && lvl[i]);
    end

    // fault summary
    pwr_flt = (power_i > st_r.upper_power_limit) ||
              (power_i < st_r.lower_power_limit);
    any_fault = (|fault_i) || (|uflt) || pwr_flt;
    any_warn = |warn_i;

    // edge functions act once per settled edge
    for (int i = 0; i < 8; i++) begin
      unique case (st_r.in_fn[i])
        `IFN_MUTE: begin
          if (fall[i]) begin
            st_nxt.mute = 1'b1;
          end
        end
        `IFN_UNMUTE: begin
          if (fall[i]) begin
            st_nxt.mute = 1'b0;
          end
        end
        `IFN_TOGGLE: begin
          if (fall[i]) begin
            st_nxt.mute = ~st_nxt.mute;
          end
        end
        `IFN_LEVEL_MUTE: begin
          // level_mute_control_input: low mutes, high unmutes
          if (fall[i]) begin
            st_nxt.mute = 1'b1;
          end else if (rise[i]) begin
            st_nxt.mute = 1'b0;
          end
        end
        `IFN_FLT_RESET: begin
          if (fall[i]) begin
            rst_ev = 1'b1;
          end
        end
        default: begin
          // no edge action for other codes
        end
      endcase
    end

    // serial commands
    if (hit) begin
      st_nxt.resp.valid = 1'b1;
      unique case (cmd_i.op)
        OP_FAULT_SUM: begin
          st_nxt.resp.data = {30'h0, any_warn, any_fault};
        end
        OP_CLEAR_REQ: begin
          clr_ev = 1'b1;
        end
        OP_FAULT_RESET: begin
          rst_ev = 1'b1;
        end
        OP_FAULT_DETAIL: begin
          st_nxt.resp.data = {7'h0, pwr_flt, uflt, warn_i, fault_i};
        end
        OP_IN_STATE: begin
          st_nxt.resp.data = {15'h0, pio_err_i, st_r.latched, lvl};
        end
        OP_IN_FN: begin
          if (cmd_i.write) begin
            st_nxt.in_fn[cmd_i.idx] = cmd_i.wdata;
          end
          st_nxt.resp.data = {24'h0, st_r.in_fn[cmd_i.idx]};
        end
        OP_OUT_FN: begin
          if (cmd_i.write) begin
            st_nxt.out_fn[cmd_i.idx] = cmd_i.wdata;
          end
          st_nxt.resp.data = {24'h0, st_r.out_fn[cmd_i.idx]};
        end
        OP_OUT_CTRL: begin
          if (cmd_i.write) begin
            st_nxt.out_ctrl = cmd_i.wdata;
          end
          st_nxt.resp.data = {24'h0, st_r.out_ctrl};
        end
        OP_SETUP: begin
          // line, baud and address stay untouched
          st_nxt.resp.reject = 1'b1;
        end
        default: begin
          st_nxt.resp.reject = 1'b1;
        end
      endcase
    end

    // latch of unassigned inputs, cleared by a serial state read, new high wins
    if (hit && cmd_i.op == OP_IN_STATE) begin
      st_nxt.latched = 8'h00;
    end
    for (int i = 0; i < 8; i++) begin
      if (st_r.in_fn[i] != `IFN_NONE) begin
        st_nxt.latched[i] = 1'b0;
      end else if (lvl[i]) begin
        st_nxt.latched[i] = 1'b1;
      end
    end

    // alarm relay state, a present condition wins over the clear
    ok_rst = rst_ev && !any_fault;
    if (ok_rst) begin
      st_nxt.flt_latch = 1'b0;
    end
    if (any_fault) begin
      st_nxt.flt_latch = 1'b1;
    end
    if (ok_rst || (clr_ev && !any_fault && !any_warn)) begin
      st_nxt.svc_req = 1'b0;
    end
    if (any_fault || any_warn) begin
      st_nxt.svc_req = 1'b1;
    end

    // relay selection by mode
    unique case (st_r.mode)
      RLY_LATCHED: st_nxt.relay = st_nxt.flt_latch;
      RLY_ACTIVE: st_nxt.relay = st_r.panel ? st_nxt.svc_req : any_fault;
      default: st_nxt.relay = st_nxt.svc_req;
    endcase
    st_nxt.panel_relay = st_nxt.svc_req;

    // parallel relays
    for (int i = 0; i < 8; i++) begin
      unique case (st_r.out_fn[i])
        `OFN_NONE: st_nxt.pio_relay[i] = st_r.out_ctrl[i];
        `OFN_PWR_FLT: st_nxt.pio_relay[i] = pwr_flt;
        default: st_nxt.pio_relay[i] = 1'b0;
      endcase
    end

    // level outputs
    st_nxt.tx_inhibit = |inh;
    st_nxt.analog = power_i;
    st_nxt.line_en = line_onehot(st_r.line);
    st_nxt.baud_div = baud_div(st_r.baud_sel);

    // local setup writes over the register port
    if (reg_we_i) begin
      unique case (reg_addr_i)
        `OFS_SETUP: begin
          st_nxt.line = line_std_e'(reg_wdata_i[`SETUP_LINE_LSB +: 2]);
          st_nxt.baud_sel = reg_wdata_i[`SETUP_BAUD_LSB +: 3];
          st_nxt.unit_addr = reg_wdata_i[`SETUP_ADDR_LSB +: 8];
          st_nxt.mode = relay_mode_e'(reg_wdata_i[`SETUP_MODE_LSB +: 2]);
          st_nxt.panel = reg_wdata_i[`SETUP_PANEL_BIT];
        end
        `OFS_PLIM: begin
          st_nxt.upper_power_limit = reg_wdata_i[15:8];
          st_nxt.lower_power_limit = reg_wdata_i[7:0];
        end
        `OFS_INFN_LO: st_nxt.in_fn[3:0] = reg_wdata_i;
        `OFS_INFN_HI: st_nxt.in_fn[7:4] = reg_wdata_i;
        `OFS_OUTFN_LO: st_nxt.out_fn[3:0] = reg_wdata_i;
        `OFS_OUTFN_HI: st_nxt.out_fn[7:4] = reg_wdata_i;
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end

    // register reads, unmapped reads as zero
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `OFS_SETUP: begin
          st_nxt.rdata = {13'h0, st_r.panel, st_r.mode, st_r.unit_addr,
                          3'h0, st_r.baud_sel, st_r.line};
        end
        `OFS_PLIM: st_nxt.rdata = {16'h0, st_r.upper_power_limit, st_r.lower_power_limit};
        `OFS_INFN_LO: st_nxt.rdata = pack4(st_r.in_fn, 1'b0);
        `OFS_INFN_HI: st_nxt.rdata = pack4(st_r.in_fn, 1'b1);
        `OFS_OUTFN_LO: st_nxt.rdata = pack4(st_r.out_fn, 1'b0);
        `OFS_OUTFN_HI: st_nxt.rdata = pack4(st_r.out_fn, 1'b1);
        `OFS_STATUS: begin
          st_nxt.rdata = {20'h0, st_r.tx_inhibit, st_r.mute, st_r.panel_relay,
                          st_r.relay, st_r.svc_req, st_r.flt_latch, pwr_flt,
                          |uflt, any_warn, any_fault, pio_err_i, 1'b0};
        end
        `OFS_INSTATE: st_nxt.rdata = {15'h0, pio_err_i, st_r.latched, lvl};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // ----
  // state register
  // ----
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.line <= LINE_SINGLE;
      st_r.baud_sel <= `RST_BAUD_SEL;
      st_r.unit_addr <= `RST_UNIT_ADDR;
      st_r.mode <= RLY_LATCHED;
      st_r.upper_power_limit <= `RST_UPPER_LIM;
      st_r.lower_power_limit <= `RST_LOWER_LIM;
      st_r.in_fn <= {8{`IFN_NONE}};
      st_r.out_fn <= {8{`OFN_NONE}};
      st_r.out_ctrl <= 8'h00;
      st_r.line_en <= 4'h1;
      st_r.baud_div <= 20'h0_5161;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----
  // outputs
  // ----
  assign reg_rdata_o = st_r.rdata;
  assign resp_o = st_r.resp;
  assign line_en_o = st_r.line_en;
  assign baud_div_o = st_r.baud_div;
  assign frame_bits_o = `FRAME_DATA_BITS;
  assign relay_o = st_r.relay;
  assign panel_relay_o = st_r.panel_relay;
  assign pio_relay_o = st_r.pio_relay;
  assign tx_inhibit_o = st_r.tx_inhibit;
  assign mute_o = st_r.mute;
  assign analog_o = st_r.analog;
endmodule

/* src/amp_rio_cfg.svh */
// Purpose: constants of the remote I/O block
// Assumes: 200 MHz system clock, 32-bit register port
// Notes: definitions only
`ifndef AMP_RIO_CFG_SVH
`define AMP_RIO_CFG_SVH

// ----
// clock
// ----
`define CLK_HZ 32'd200000000

// ----
// register byte offsets
// ----
`define OFS_SETUP 8'h00
`define OFS_PLIM 8'h04
`define OFS_INFN_LO 8'h08
`define OFS_INFN_HI 8'h0C
`define OFS_OUTFN_LO 8'h10
`define OFS_OUTFN_HI 8'h14
`define OFS_STATUS 8'h18
`define OFS_INSTATE 8'h1C

// ----
// setup word field positions
// ----
`define SETUP_LINE_LSB 0
`define SETUP_BAUD_LSB 2
`define SETUP_ADDR_LSB 8
`define SETUP_MODE_LSB 16
`define SETUP_PANEL_BIT 18

// ----
// reset values and broadcast address
// ----
`define RST_BAUD_SEL 3'h4
`define RST_UNIT_ADDR 8'h00
`define RST_UPPER_LIM 8'hFF
`define RST_LOWER_LIM 8'h00
`define RST_SYNC 8'hFF
`define BCAST_ADDR 8'h00

// ----
// character framing
// ----
`define FRAME_DATA_BITS 4'h8

// ----
// input function codes
// ----
`define IFN_NONE 8'h30
`define IFN_MUTE 8'h33
`define IFN_UNMUTE 8'h34
`define IFN_TOGGLE 8'h35
`define IFN_LEVEL_MUTE 8'h46
`define IFN_UFLT_LOW 8'h44
`define IFN_UFLT_HIGH 8'h32
`define IFN_INH_LOW 8'h36
`define IFN_INH_HIGH 8'h37
`define IFN_FLT_RESET 8'h38

// ----
// output function codes
// ----
`define OFN_NONE 8'h30
`define OFN_PWR_FLT 8'h31

`endif

/* src/amp_rio_pkg.sv */
// Purpose: types shared by the remote I/O block
// Assumes: codes and offsets live in amp_rio_cfg.svh
// Notes: none
package amp_rio_pkg;

  // ----
  // setup modes
  // ----
  typedef enum logic [1:0] {
    LINE_SINGLE = 2'h0,  // single-ended
    LINE_DIFF4 = 2'h1,   // four-wire differential
    LINE_DIFF2 = 2'h2,   // two-wire differential
    LINE_P2P = 2'h3      // point-to-point differential
  } line_std_e;

  typedef enum logic [1:0] {
    RLY_LATCHED = 2'h0,  // latched fault
    RLY_SVC_REQ = 2'h1,  // attention request
    RLY_ACTIVE = 2'h2    // active fault
  } relay_mode_e;

  // ----
  // decoded serial commands
  // ----
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_FAULT_SUM = 4'h1,     // short fault summary
    OP_CLEAR_REQ = 4'h2,     // clear attention request
    OP_FAULT_RESET = 4'h3,   // fault reset
    OP_FAULT_DETAIL = 4'h4,  // detailed fault list
    OP_IN_STATE = 4'h5,      // input latched and current state
    OP_IN_FN = 4'h6,         // input function read or write
    OP_OUT_FN = 4'h7,        // output function read or write
    OP_OUT_CTRL = 4'h8,      // unassigned output control
    OP_SETUP = 4'h9          // attempt to change line, baud or address
  } cmd_e;

  typedef struct packed {
    logic valid;         // one-cycle command pulse
    logic [7:0] addr;    // header address
    cmd_e op;            // decoded command
    logic write;         // write instead of read
    logic [2:0] idx;     // input or output number
    logic [7:0] wdata;   // written value
  } cmd_s;

  typedef struct packed {
    logic valid;         // one-cycle answer pulse
    logic reject;        // command refused
    logic [31:0] data;   // answer payload
  } resp_s;

  typedef struct packed {
    logic [7:0] s1;      // first synchroniser stage
    logic [7:0] s2;      // second synchroniser stage
    logic [7:0] last;    // previous settled level
  } sync_s;

endpackage

/* src/pio_input_sync.sv */
// Purpose: two-flop synchroniser and edge detect for the parallel inputs
// Assumes: pins idle high when open
// Notes: edge outputs are one-cycle pulses
`timescale 1ns/100ps
`include "amp_rio_cfg.svh"

module pio_input_sync (
  input wire logic clk_i,         // system clock
  input wire logic srst_i,        // synchronous reset
  input wire logic [7:0] pin_i,   // raw input pins
  output logic [7:0] level_o,     // settled level
  output logic [7:0] rise_o,      // rising edge pulse
  output logic [7:0] fall_o       // falling edge pulse
);
  import amp_rio_pkg::*;

  sync_s st_r;   // registered state
  sync_s st_nxt; // next state

  // ----
  // next state
  // ----
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.last = st_r.s2;
  end

  // ----
  // state register
  // ----
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '{s1: `RST_SYNC, s2: `RST_SYNC, last: `RST_SYNC};
    end else begin
      st_r <= st_nxt;
    end
  end

  // edge detection looks only at settled stages
  assign level_o = st_r.s2;
  assign rise_o = st_r.s2 & ~st_r.last;
  assign fall_o = ~st_r.s2 & st_r.last;
endmodule

/* tb/amp_remote_io_sva.sv */
// Purpose: port checks of amp_remote_io
// Assumes: address and mode tracked from setup writes
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`include "amp_rio_cfg.svh"
module amp_remote_io_sva import amp_rio_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic srst_i, // reset
  input wire logic [7:0] reg_addr_i, // address
  input wire logic [31:0] reg_wdata_i, // write data
  input wire logic reg_we_i, // write strobe
  input wire amp_rio_pkg::cmd_s cmd_i, // command
  input wire amp_rio_pkg::resp_s resp_o, // answer
  input wire logic [7:0] fault_i, // faults
  input wire logic [7:0] power_i, // power
  input wire logic [3:0] line_en_o, // line enable
  input wire logic [19:0] baud_div_o, // divider
  input wire logic [3:0] frame_bits_o, // data bits
  input wire logic relay_o, // relay
  input wire logic [7:0] analog_o // analog
);
  logic [7:0] unit_r; // tracked unit address
  logic [1:0] mode_r; // tracked relay mode
  logic hit; // command meant for this unit
  assign hit = cmd_i.valid && (cmd_i.addr == 8'h00 || cmd_i.addr == unit_r);
  // follow the setup word as written
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      unit_r <= 8'h00;
      mode_r <= 2'h0;
    end else if (reg_we_i && reg_addr_i == `OFS_SETUP) begin
      unit_r <= reg_wdata_i[15:8];
      mode_r <= reg_wdata_i[17:16];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_line_onehot: assert property ($onehot(line_en_o))
    else $error("line enable not one-hot");
  a_frame_eight: assert property (frame_bits_o == `FRAME_DATA_BITS)
    else $error("frame not eight data bits");
  a_baud_legal: assert property (baud_div_o inside {20'd666666, 20'd166666, 20'd83333,
    20'd41666, 20'd20833, 20'd13888, 20'd10416, 20'd6944})
    else $error("baud divider not a listed rate");
  a_setup_refused: assert property (hit && cmd_i.op == OP_SETUP && !reg_we_i
    |=> resp_o.valid && resp_o.reject) else $error("setup command not refused");
  a_foreign_silent: assert property (cmd_i.valid && !hit && !reg_we_i
    |=> !resp_o.valid) else $error("answered foreign address");
  a_bcast_answer: assert property (cmd_i.valid && cmd_i.addr == 8'h00 |=> resp_o.valid)
    else $error("broadcast not answered");
  a_latched_hold: assert property (relay_o && mode_r == 2'h0 && !reg_we_i &&
    !$past(reg_we_i) && !(hit && cmd_i.op == OP_FAULT_RESET) |=> relay_o)
    else $error("latched relay released");
  a_fault_relay: assert property (fault_i != 8'h00 |-> ##[1:3] relay_o)
    else $error("fault did not set relay");
  a_analog_power: assert property (!$past(srst_i) |-> analog_o == $past(power_i))
    else $error("analog output not power");
endmodule
bind amp_remote_io amp_remote_io_sva amp_remote_io_sva_i (.clk_i(clk_i), .srst_i(srst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .cmd_i(cmd_i),
  .resp_o(resp_o), .fault_i(fault_i), .power_i(power_i), .line_en_o(line_en_o),
  .baud_div_o(baud_div_o), .frame_bits_o(frame_bits_o), .relay_o(relay_o),
  .analog_o(analog_o));

/* tb/amp_remote_io_tb.sv */
// Purpose: self-checking bench of amp_remote_io
// Assumes: host_model drives commands
// Notes: expected values come from the bench's own arithmetic
`timescale 1ns/100ps
`include "amp_rio_cfg.svh"
module amp_remote_io_tb;
  import amp_rio_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0, pio_err_i = 1'b0;
  logic [7:0] reg_addr_i = '0, fault_i = '0, warn_i = '0, power_i = '0, pio_pin_i = '0;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o;
  cmd_s cmd_i;
  resp_s resp_o;
  logic [3:0] line_en_o, frame_bits_o;
  logic [19:0] baud_div_o;
  logic relay_o, panel_relay_o, tx_inhibit_o, mute_o, got, pan = 1'b0, m0;
  logic [7:0] pio_relay_o, analog_o, prev;
  logic [32:0] d;
  int num_errors = 0, checks = 0;
  int rates[8] = '{300, 1200, 2400, 4800, 9600, 14400, 19200, 28800};
  logic [7:0] codes[4] = '{8'h44, 8'h32, 8'h36, 8'h37};
  amp_remote_io amp_remote_io_i (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .cmd_i(cmd_i), .resp_o(resp_o), .fault_i(fault_i),
    .warn_i(warn_i), .power_i(power_i), .pio_pin_i(pio_pin_i), .pio_err_i(pio_err_i),
    .line_en_o(line_en_o), .baud_div_o(baud_div_o), .frame_bits_o(frame_bits_o),
    .relay_o(relay_o), .panel_relay_o(panel_relay_o), .pio_relay_o(pio_relay_o),
    .tx_inhibit_o(tx_inhibit_o), .mute_o(mute_o), .analog_o(analog_o));
  host_model host_model_i (.clk_i(clk_i), .resp_i(resp_o), .cmd_o(cmd_i));
  initial forever #2.5 clk_i = ~clk_i;
  // compare and count
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] act);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, act);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a; reg_wdata_i <= v; reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a; reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = {1'b0, reg_rdata_o};
  endtask
  function automatic logic [31:0] setup_w(input logic [2:0] m, input logic [2:0] b,
    input logic [1:0] l);
    return {13'h0, m, 8'h05, 3'h0, b, l};
  endfunction
  // set levels, maybe a command, then check the relay
  task automatic step(input logic [7:0] f, input logic [7:0] w, input cmd_e op, input logic e);
    @(posedge clk_i);
    fault_i <= f; warn_i <= w;
    if (op != OP_NONE) host_model_i.send(8'h05, op, 1'b0, 3'h0, 8'h00, got, d);
    repeat (3) @(posedge clk_i);
    #1 chk("relay", {32'h0, e}, {32'h0, pan ? panel_relay_o : relay_o});
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(98));
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 chk("pio_relay", 33'h0, {25'h0, pio_relay_o});
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_SETUP, setup_w(3'h0, 3'(i), 2'(i)));
      @(posedge clk_i);
      #1 chk("line_en", 33'(1 << (i % 4)), {29'h0, line_en_o});
      chk("baud_div", 33'(200000000 / rates[i]), {13'h0, baud_div_o});
    end
    rd(`OFS_SETUP);
    chk("setup", {1'b0, setup_w(3'h0, 3'h7, 2'h3)}, d);
    host_model_i.send(8'h05, OP_SETUP, 1'b1, 3'h0, 8'h00, got, d);
    chk("reject", 33'h1, {32'h0, d[32]});
    chk("baud_kept", 33'(200000000 / 28800), {13'h0, baud_div_o});
    foreach (codes[k]) begin
      host_model_i.send(k == 2 ? 8'h06 : 8'h05 - 8'(k * 5), OP_FAULT_SUM, 1'b0, 3'h0, 8'h00, got, d);
      chk("answered", {32'h0, k < 2}, {32'h0, got});
    end
    repeat (4) begin
      @(posedge clk_i);
      fault_i <= 8'($urandom); warn_i <= 8'($urandom); power_i <= 8'($urandom);
      repeat (2) @(posedge clk_i);
      host_model_i.send(8'h00, OP_FAULT_SUM, 1'b0, 3'h0, 8'h00, got, d);
      chk("summary", {31'h0, warn_i != 0, fault_i != 0}, d);
      host_model_i.send(8'h05, OP_FAULT_DETAIL, 1'b0, 3'h0, 8'h00, got, d);
      chk("detail", {17'h0, warn_i, fault_i}, d);
    end
    step(8'h01, 8'h00, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_FAULT_RESET, 1'b0);
    wr(`OFS_SETUP, setup_w(3'h1, 3'h7, 2'h3));
    step(8'h00, 8'h04, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_CLEAR_REQ, 1'b0);
    wr(`OFS_SETUP, setup_w(3'h2, 3'h7, 2'h3));
    step(8'h80, 8'h00, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_NONE, 1'b0);
    wr(`OFS_SETUP, setup_w(3'h6, 3'h7, 2'h3));
    pan = 1'b1;
    step(8'h02, 8'h00, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_NONE, 1'b1);
    step(8'h00, 8'h00, OP_CLEAR_REQ, 1'b0);
    prev = `IFN_NONE;
    for (int k = 0; k < 8; k++) begin
      host_model_i.send(8'h00, OP_IN_FN, 1'b1, 3'h0, codes[k / 2], got, d);
      chk("in_fn", {25'h0, prev}, d);
      prev = codes[k / 2];
      @(posedge clk_i);
      pio_pin_i <= 8'(k % 2);
      repeat (4) @(posedge clk_i);
      rd(`OFS_STATUS);
      chk("user_fault", {32'h0, k < 4 && (k % 2 == (k < 2 ? 0 : 1))}, {32'h0, d[4]});
      chk("inhibit", {32'h0, k > 3 && (k % 2 == (k < 6 ? 0 : 1))}, {32'h0, tx_inhibit_o});
    end
    @(posedge clk_i);
    pio_pin_i <= 8'h00; pio_err_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    host_model_i.send(8'h05, OP_IN_STATE, 1'b0, 3'h0, 8'h00, got, d);
    pio_pin_i <= 8'h02;
    repeat (3) @(posedge clk_i);
    pio_pin_i <= 8'h00;
    repeat (4) @(posedge clk_i);
    host_model_i.send(8'h05, OP_IN_STATE, 1'b0, 3'h0, 8'h00, got, d);
    chk("in_state", 33'h10200, d);
    host_model_i.send(8'h05, OP_OUT_FN, 1'b1, 3'h2, `OFN_PWR_FLT, got, d);
    chk("out_fn", {25'h0, `OFN_NONE}, d);
    wr(`OFS_PLIM, 32'h0000_8010);
    foreach (codes[k]) begin
      @(posedge clk_i);
      power_i <= k < 2 ? 8'h81 - 8'(k) : 8'h12 - 8'(k);
      repeat (3) @(posedge clk_i);
      rd(`OFS_STATUS);
      chk("pwr_fault", {32'h0, k == 0 || k == 3}, {32'h0, d[5]});
    end
    host_model_i.send(8'h05, OP_IN_FN, 1'b1, 3'h3, `IFN_TOGGLE, got, d);
    pio_pin_i <= 8'h08;
    repeat (5) @(posedge clk_i);
    m0 = mute_o;
    pio_pin_i <= 8'h00;
    repeat (8) @(posedge clk_i);
    #1 chk("mute_toggle", {32'h0, ~m0}, {32'h0, mute_o});
    wrap_up();
  end
endmodule

/* tb/host_model.sv */
// Purpose: polling monitor-and-control host on the command port
// Assumes: answer one cycle after the command
// Notes: send returns {reject, data}
`timescale 1ns/100ps
module host_model import amp_rio_pkg::*; (
  input wire logic clk_i, // clock
  input wire amp_rio_pkg::resp_s resp_i, // answer
  output amp_rio_pkg::cmd_s cmd_o // command
);
  initial cmd_o = '0;
  // one command, answer taken next cycle
  task automatic send(input logic [7:0] a, input cmd_e op, input logic w,
    input logic [2:0] ix, input logic [7:0] wd, output logic got, output logic [32:0] d);
    @(posedge clk_i);
    cmd_o <= '{1'b1, a, op, w, ix, wd};
    @(posedge clk_i);
    cmd_o.valid <= 1'b0;
    #1 got = resp_i.valid;
    d = {resp_i.reject, resp_i.data};
  endtask
endmodule
